/* File: src/reset_and_runaway_watchdog.sv */
`timescale 1ns/1ps
module reset_and_runaway_watchdog #(
    parameter int          PRESCALE_DIV      = reset_wdt_pkg::PRESCALE_DIV_DEF,
    parameter int          RESET_CYCLE_TICKS = reset_wdt_pkg::RESET_LONG_TICKS,
    parameter int          WDT_INTERVAL      = reset_wdt_pkg::WDT_INT_LONG,
    parameter bit          PIN_LEVEL_MODE    = 1'b1,
    parameter bit          POR_ENABLE        = 1'b1,
    parameter bit          LCD_UNLIGHT       = 1'b0,
    parameter logic [3:0]  KEY_RESET_SELECT  = 4'h0
) (
    // clock and reset
    input  wire logic                                 clk_in,
    input  wire logic                                 rst_n_in,
    // reset sources
    input  wire logic                                 power_on_detect_in,
    input  wire logic                                 reset_pin_in,
    input  wire logic [reset_wdt_pkg::KEY_W-1:0]      key_scan_inputs_in,
    input  wire logic [reset_wdt_pkg::KEY_W-1:0]      key_input_mode_in,
    input  wire logic                                 key_scan_done_in,
    // axi4-lite write
    input  wire logic [reset_wdt_pkg::ADDR_W-1:0]     awaddr_in,
    input  wire logic                                 awvalid_in,
    output logic                                      awready_out,
    input  wire logic [31:0]                          wdata_in,
    input  wire logic [3:0]                           wstrb_in,
    input  wire logic                                 wvalid_in,
    output logic                                      wready_out,
    output logic [1:0]                                bresp_out,
    output logic                                      bvalid_out,
    input  wire logic                                 bready_in,
    // axi4-lite read
    input  wire logic [reset_wdt_pkg::ADDR_W-1:0]     araddr_in,
    input  wire logic                                 arvalid_in,
    output logic                                      arready_out,
    output logic [31:0]                               rdata_out,
    output logic [1:0]                                rresp_out,
    output logic                                      rvalid_out,
    input  wire logic                                 rready_in,
    // reset results
    output logic                                      sys_reset_out,
    output reset_wdt_pkg::init_type                   reset_values_out,
    output logic                                      lcd_all_lit_out,
    output logic                                      watchdog_enabled_flag_out
);
    import reset_wdt_pkg::*;

    typedef struct packed {
        logic                   pin_s1;
        logic                   pin_s2;
        logic                   pin_prev;
        logic                   por_s1;
        logic                   por_s2;
        logic [KEY_W-1:0]       key_s1;
        logic [KEY_W-1:0]       key_s2;
        logic [DIV_W-1:0]       div_cnt;
        logic [STAGE_W-1:0]     stage_cnt;
        phase_type              phase;
        logic [CYC_W-1:0]       cyc_cnt;
        cause_type              cause;
        logic                   core_reset;
        init_type               init;
        logic                   lcd_lit;
        logic [WDT_W-1:0]       wdt_cnt;
        logic                   wdt_en;
        logic                   halt;
        logic                   stop;
        logic                   aw_got;
        logic                   w_got;
        logic [ADDR_W-1:0]      awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_type;

    state_type s;
    state_type next_s;

    logic             pre_tick;
    logic             ten_tick;
    logic [KEY_W-1:0] key_sel;
    logic             por_req;
    logic             pin_req;
    logic             key_req;
    logic             full_req;
    logic             wr_fire;
    logic             kick;
    logic             wdt_ovf;

    // ****************************************
    // request decode
    // ****************************************
    // sources are combined into one request; the first flops are never read here
    always_comb begin
        pre_tick = (s.div_cnt == DIV_W'(PRESCALE_DIV - 1));
        ten_tick = pre_tick && (&s.stage_cnt[STAGE_TEN_BITS-1:0]);
        key_sel  = KEY_RESET_SELECT & key_input_mode_in;
        por_req  = POR_ENABLE && s.por_s2;
        pin_req  = PIN_LEVEL_MODE ? s.pin_s2 : (s.pin_s2 && !s.pin_prev);
        key_req  = key_scan_done_in && (key_sel != '0)
                   && ((s.key_s2 & key_sel) == '0);
        full_req = por_req || pin_req || key_req;
        wr_fire  = s.aw_got && s.w_got && !s.bvalid;
        kick     = wr_fire && (s.awaddr == OFF_CONTROL) && s.wstrb[0]
                   && s.wdata[CTL_KICK];
        wdt_ovf  = s.wdt_en && ten_tick && !s.halt && !s.stop && !kick
                   && (s.wdt_cnt == WDT_W'(WDT_INTERVAL - 1));
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        // pins come from outside: two flops before use
        next_s.pin_s1   = reset_pin_in;
        next_s.pin_s2   = s.pin_s1;
        next_s.pin_prev = s.pin_s2;
        next_s.por_s1   = power_on_detect_in;
        next_s.por_s2   = s.por_s1;
        next_s.key_s1   = key_scan_inputs_in;
        next_s.key_s2   = s.key_s1;

        // prescaler keeps running through a reset cycle, it times the cycle
        next_s.div_cnt = pre_tick ? '0 : DIV_W'(s.div_cnt + 1'b1);
        if (pre_tick) begin
            next_s.stage_cnt = STAGE_W'(s.stage_cnt + 1'b1);
        end

        // reset sequencer
        case (s.phase)
            ST_RUN: begin
                next_s.core_reset = 1'b0;
            end
            ST_HOLD: begin
                if (!s.pin_s2) begin
                    next_s.phase   = ST_CYCLE;
                    next_s.cyc_cnt = '0;
                end
            end
            ST_CYCLE: begin
                if (pre_tick) begin
                    if (s.cyc_cnt == CYC_W'(RESET_CYCLE_TICKS - 1)) begin
                        next_s.phase      = ST_RUN;
                        next_s.core_reset = 1'b0;
                    end else begin
                        next_s.cyc_cnt = CYC_W'(s.cyc_cnt + 1'b1);
                    end
                end
            end
            default: begin
                next_s.phase = ST_CYCLE;
            end
        endcase
        if (full_req || wdt_ovf) begin
            next_s.core_reset = 1'b1;
            next_s.cyc_cnt    = '0;
            next_s.halt       = 1'b0;
            next_s.stop       = 1'b0;
            // level mode stays in hold while the pin is high
            next_s.phase = (PIN_LEVEL_MODE && s.pin_s2) ? ST_HOLD : ST_CYCLE;
            if (por_req) begin
                next_s.cause = CAUSE_POR;
            end else if (pin_req) begin
                next_s.cause = CAUSE_PIN;
            end else if (key_req) begin
                next_s.cause = CAUSE_KEY;
            end else begin
                next_s.cause = CAUSE_WDT;
            end
            // overflow spares stages up to ten, a full reset clears them all
            if (full_req) begin
                next_s.stage_cnt = '0;
                next_s.div_cnt   = '0;
            end else begin
                next_s.stage_cnt[STAGE_W-1:STAGE_TEN_BITS] = '0;
            end
        end
        // reset values stand constant; loaded by the core while reset is high
        next_s.init    = INIT_VALUES;
        next_s.lcd_lit = next_s.core_reset && !LCD_UNLIGHT;

        // watchdog: full reset disables, kick wins over counting
        if (full_req) begin
            next_s.wdt_en  = 1'b0;
            next_s.wdt_cnt = '0;
        end else if (kick) begin
            next_s.wdt_en  = 1'b1;
            next_s.wdt_cnt = '0;
        end else if (s.wdt_en && ten_tick && !s.halt && !s.stop) begin
            next_s.wdt_cnt = wdt_ovf ? '0 : WDT_W'(s.wdt_cnt + 1'b1);
        end

        // axi write channel
        if (awvalid_in && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = awaddr_in;
        end
        if (wvalid_in && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = wdata_in;
            next_s.wstrb = wstrb_in;
        end
        if (s.bvalid && bready_in) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            if (s.awaddr == OFF_CONTROL) begin
                if (s.wstrb[0] && !full_req && !wdt_ovf) begin
                    next_s.halt = s.wdata[CTL_HALT];
                    next_s.stop = s.wdata[CTL_STOP];
                end
            end else if (s.awaddr != OFF_STATUS) begin
                next_s.bresp = RESP_SLVERR;     // any other offset is unmapped and refused; status writes are ignored with okay
            end
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        // axi read channel: one outstanding read, answered next cycle
        if (s.rvalid && rready_in) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid_in && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            next_s.rdata  = '0;
            if (araddr_in == OFF_CONTROL) begin
                next_s.rdata[CTL_HALT] = s.halt;
                next_s.rdata[CTL_STOP] = s.stop;
            end else if (araddr_in == OFF_STATUS) begin
                next_s.rdata[STS_WDT_EN]                     = s.wdt_en;
                next_s.rdata[STS_IN_RESET]                   = s.core_reset;
                next_s.rdata[STS_CAUSE_LO+:3]                = s.cause;
                next_s.rdata[STS_CNT_LO+:WDT_W]              = s.wdt_cnt;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
        end
        next_s.arready = !next_s.rvalid;

        // block reset behaves like power-on: full cycle, watchdog off
        if (!rst_n_in) begin
            next_s            = '0;
            next_s.phase      = ST_CYCLE;
            next_s.core_reset = 1'b1;
            next_s.cause      = CAUSE_POR;
            next_s.init       = INIT_VALUES;
            next_s.lcd_lit    = !LCD_UNLIGHT;
            next_s.awready    = 1'b1;
            next_s.wready     = 1'b1;
            next_s.arready    = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge clk_in) begin
        s <= next_s;
    end

    // ****************************************
    // outputs, all straight from flops
    // ****************************************
    assign awready_out               = s.awready;
    assign wready_out                = s.wready;
    assign bvalid_out                = s.bvalid;
    assign bresp_out                 = s.bresp;
    assign arready_out               = s.arready;
    assign rvalid_out                = s.rvalid;
    assign rdata_out                 = s.rdata;
    assign rresp_out                 = s.rresp;
    assign sys_reset_out             = s.core_reset;
    assign reset_values_out          = s.init;
    assign lcd_all_lit_out           = s.lcd_lit;
    assign watchdog_enabled_flag_out = s.wdt_en;

    // ****************************************
    // checks
    // ****************************************
    // all checks run on the one clock and stay quiet while the block reset is low
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // watchdog: kick, pause, overflow and range
    a_kick_clears_wdt: assert property (
        kick && !full_req |=> s.wdt_en && s.wdt_cnt == '0)
        else $error("kick did not enable and clear watchdog");
    a_halt_holds_cnt: assert property (
        (s.halt || s.stop) && !kick && !full_req |=> $stable(s.wdt_cnt))
        else $error("watchdog counted during halt or stop");
    a_ovf_keeps_wdt: assert property (
        wdt_ovf && !full_req |=> s.core_reset && s.wdt_en && s.cause == CAUSE_WDT)
        else $error("overflow reset wrong");
    // compared as int: a 512 interval cut to nine bits would read as zero
    a_wdt_in_range: assert property (
        int'(s.wdt_cnt) < WDT_INTERVAL)
        else $error("watchdog count past interval");
    a_full_stops_wdt: assert property (
        por_req || pin_req |=> !s.wdt_en)
        else $error("watchdog still enabled after pin or power-on reset");

    // sequencer: hold, cycle length, sources
    a_level_hold: assert property (
        PIN_LEVEL_MODE && s.pin_s2 |=> s.phase == ST_HOLD && s.core_reset)
        else $error("level reset not held");
    a_cycle_length: assert property (
        $fell(s.core_reset) |-> $past(s.cyc_cnt) == CYC_W'(RESET_CYCLE_TICKS - 1))
        else $error("reset released early");
    a_key_starts: assert property (
        key_req |=> s.core_reset)
        else $error("key condition did not reset");
    a_pulse_frees: assert property (
        !PIN_LEVEL_MODE && pin_req |=> s.phase == ST_CYCLE)
        else $error("pulse reset did not start cycle");
    // pulse mode must never wait on the pin level
    a_pulse_no_hold: assert property (
        !PIN_LEVEL_MODE |-> s.phase != ST_HOLD)
        else $error("pulse reset waited for the pin");
    a_por_cause: assert property (
        por_req |=> s.core_reset && s.cause == CAUSE_POR)
        else $error("power-on request not taken");
    a_run_released: assert property (
        s.phase == ST_RUN |-> !s.core_reset)
        else $error("core reset high while running");
    a_lcd_lit: assert property (
        s.core_reset && $past(s.core_reset) |-> s.lcd_lit == !LCD_UNLIGHT)
        else $error("lcd state wrong in reset");

    // main scenarios
    c_wdt_ovf:  cover property (wdt_ovf);
    c_key_rst:  cover property (key_req);
    c_por_rst:  cover property (por_req);
    c_hold:     cover property (s.phase == ST_HOLD ##1 s.phase == ST_CYCLE);
    c_release:  cover property ($fell(s.core_reset));
endmodule

/* File: src/reset_wdt_pkg.sv */
package reset_wdt_pkg;
    // ****************************************
    // clock and prescaler
    // ****************************************
    localparam int CLK_HZ             = 40_000_000;
    localparam int PRESCALER_INPUT_HZ = 32_768;
    localparam int PRESCALE_DIV_DEF   = CLK_HZ / PRESCALER_INPUT_HZ;
    localparam int DIV_W              = 16;
    localparam int STAGE_W            = 16;
    localparam int STAGE_TEN_BITS     = 10;   // stage ten is 2^10 input clocks
    // ****************************************
    // reset cycle and watchdog
    // ****************************************
    localparam int RESET_LONG_TICKS   = 16384;
    localparam int RESET_SHORT_TICKS  = 2048;
    localparam int CYC_W              = 16;
    localparam int WDT_W              = 9;
    localparam int WDT_INT_SHORT      = 8;
    localparam int WDT_INT_MID        = 64;
    localparam int WDT_INT_LONG       = 512;
    localparam int KEY_W              = 4;
    // ****************************************
    // register map
    // ****************************************
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFF_CONTROL  = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam int          CTL_KICK     = 0;
    localparam int          CTL_HALT     = 1;
    localparam int          CTL_STOP     = 2;
    localparam int          STS_WDT_EN   = 0;
    localparam int          STS_IN_RESET = 1;
    localparam int          STS_CAUSE_LO = 2;
    localparam int          STS_CNT_LO   = 16;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ****************************************
    // reset state values
    // ****************************************
    localparam logic [11:0] PC_RESET_VALUE  = 12'h000;
    localparam logic [3:0]  SEL_INPUT_CLOCK = 4'h0;
    localparam logic [3:0]  SEL_STAGE_EIGHT = 4'h8;
    localparam logic [3:0]  SEL_STAGE_TEN   = 4'ha;
    localparam logic [1:0]  DUTY_QUARTER    = 2'h0;
    localparam logic        CLK_SRC_CRYSTAL = 1'b0;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_HOLD  = 2'b01,
        ST_CYCLE = 2'b10
    } phase_type;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_POR  = 3'b001,
        CAUSE_PIN  = 3'b010,
        CAUSE_KEY  = 3'b011,
        CAUSE_WDT  = 3'b100
    } cause_type;

    // values the rest of the chip loads while the reset cycle runs
    typedef struct packed {
        logic [11:0] pc_value;
        logic [6:0]  start_condition_flags;
        logic [3:0]  stop_release_enables;
        logic [1:0]  switch_enables;
        logic [6:0]  halt_release_requests;
        logic [5:0]  halt_release_enables;
        logic [6:0]  interrupt_enables;
        logic [3:0]  pulldown_port_c;
        logic [3:0]  pulldown_port_d;
        logic [15:0] port_output_mode;   // a,b,c,d; zero means input
        logic [3:0]  debounce_clk_sel;
        logic [3:0]  el_pump_clk_sel;
        logic [1:0]  el_pump_duty;
        logic [3:0]  el_clear_clk_sel;
        logic [1:0]  el_clear_duty;
        logic [3:0]  freq_gen_clk_sel;
        logic [1:0]  freq_gen_duty;
        logic        freq_gen_out_en;
        logic        resistor_freq_converter_en;
        logic [2:0]  converter_drive_pins;
        logic        base_clock_sel;
    } init_type;

    localparam init_type INIT_VALUES = '{
        pc_value:                   PC_RESET_VALUE,
        start_condition_flags:      '0,
        stop_release_enables:       '0,
        switch_enables:             '0,
        halt_release_requests:      '0,
        halt_release_enables:       '0,
        interrupt_enables:          '0,
        pulldown_port_c:            '1,
        pulldown_port_d:            '1,
        port_output_mode:           '0,
        debounce_clk_sel:           SEL_STAGE_TEN,
        el_pump_clk_sel:            SEL_INPUT_CLOCK,
        el_pump_duty:               DUTY_QUARTER,
        el_clear_clk_sel:           SEL_STAGE_EIGHT,
        el_clear_duty:              DUTY_QUARTER,
        freq_gen_clk_sel:           SEL_INPUT_CLOCK,
        freq_gen_duty:              DUTY_QUARTER,
        freq_gen_out_en:            1'b0,
        resistor_freq_converter_en: 1'b0,
        converter_drive_pins:       '0,
        base_clock_sel:             CLK_SRC_CRYSTAL
    };
endpackage

/* File: test/reset_source_model.sv */
`timescale 1ns/1ps
// ****************************************
// pins and keys outside the block
// ****************************************
module reset_source_model (
    // pins toward the block
    output logic       pin_out,
    output logic       por_out,
    output logic [3:0] keys_out,
    output logic       scan_done_out
);
    // pull-down keeps the reset pin low; keys idle released (high)
    initial begin
        pin_out       = 1'b0;
        por_out       = 1'b0;
        keys_out      = 4'hf;
        scan_done_out = 1'b0;
    end
    // caller decides how long the pin stays high, short pulse or long hold
    task set_pin(input logic level);
        pin_out <= level;
    endtask
    // supply monitor level, high while power is judged unsafe
    task set_por(input logic level);
        por_out <= level;
    endtask
    // levels only count once the scan flag says they are settled
    task set_keys(input logic [3:0] levels, input logic scanned);
        keys_out      <= levels;
        scan_done_out <= scanned;
    endtask
endmodule

/* File: test/test_reset_and_runaway_watchdog.sv */
`timescale 1ns/1ps
module test_reset_and_runaway_watchdog;
    import reset_wdt_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, awvalid_in = 1'b0, wvalid_in = 1'b0;
    logic arvalid_in = 1'b0, bready_in = 1'b0, rready_in = 1'b0;
    logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, rd;
    logic [3:0] wstrb_in = 4'hf, key_input_mode_in = 4'hf, key_scan_inputs_in;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, sys_reset_out;
    logic power_on_detect_in, reset_pin_in, key_scan_done_in, lcd_all_lit_out;
    logic watchdog_enabled_flag_out;
    logic [1:0] bresp_out, rresp_out, resp;
    init_type reset_values_out;
    int fail_count = 0, total_checks = 0, cyc = 0;
    // ****************************************
    // clock, timeout, instances
    // ****************************************
    always #12.5 clk_in = ~clk_in;
    // whole sequence needs about 21000 cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            stop_test;
        end
    end
    // short counts keep the run brief; pins 0 and 1 join key reset
    reset_and_runaway_watchdog #(.PRESCALE_DIV(2), .RESET_CYCLE_TICKS(4), .WDT_INTERVAL(8),
        .KEY_RESET_SELECT(4'h3)) u_reset_and_runaway_watchdog (.clk_in, .rst_n_in,
        .power_on_detect_in, .reset_pin_in, .key_scan_inputs_in, .key_input_mode_in,
        .key_scan_done_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in,
        .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
        .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in, .sys_reset_out,
        .reset_values_out, .lcd_all_lit_out, .watchdog_enabled_flag_out);
    reset_source_model u_reset_source_model (.pin_out(reset_pin_in),
        .por_out(power_on_detect_in), .keys_out(key_scan_inputs_in),
        .scan_done_out(key_scan_done_in));
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        awaddr_in <= a;
        wdata_in <= d;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        // each channel is released at the edge that takes it
        do begin
            @(posedge clk_in);
            if (awready_out) awvalid_in <= 1'b0;
            if (wready_out) wvalid_in <= 1'b0;
        end while (!(awvalid_in == 1'b0 || awready_out) || !(wvalid_in == 1'b0 || wready_out));
        while (bvalid_out !== 1'b1) @(posedge clk_in);
        resp = bresp_out;
        bready_in <= 1'b0;
        chk("bresp", resp, exp);
        // one idle edge so a following call never re-raises bready in this step
        @(posedge clk_in);
    endtask
    task rd_reg(input logic [7:0] a, input logic [1:0] exp);
        araddr_in <= a;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        do @(posedge clk_in); while (arready_out !== 1'b1);
        arvalid_in <= 1'b0;
        while (rvalid_out !== 1'b1) @(posedge clk_in);
        rd = rdata_out;
        resp = rresp_out;
        rready_in <= 1'b0;
        chk("rresp", resp, exp);
        @(posedge clk_in);
    endtask
    // waits for the core reset to reach a level, inside a window of cycles
    task wait_rst(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (sys_reset_out !== v && n < hi) begin
            @(posedge clk_in);
            n++;
        end
        chk("sys_reset", sys_reset_out, v);
        chk("reset_delay_in_window", n >= lo && n < hi, 1'b1);
    endtask
    task stop_test;
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_rst(1'b0, 6, 200);
        chk("reset_values", reset_values_out, INIT_VALUES);
        chk("wdt_flag", watchdog_enabled_flag_out, 1'b0);
        wr(OFF_CONTROL, 32'h1, RESP_OKAY);
        chk("wdt_flag", watchdog_enabled_flag_out, 1'b1);
        // status write is ignored with okay, an unmapped one is refused
        wr(OFF_STATUS, 32'h1, RESP_OKAY);
        wr(8'h0c, 32'h1, RESP_SLVERR);
        rd_reg(8'h08, RESP_SLVERR);
        // firmware kicks as it halts, so the count starts from zero
        wr(OFF_CONTROL, 32'h3, RESP_OKAY);
        repeat (5000) @(posedge clk_in);
        rd_reg(OFF_STATUS, RESP_OKAY);
        chk("count_in_halt", rd[24:16], 9'h000);
        // no more kicks: overflow after 8 stage-ten periods of 2048 clocks
        wr(OFF_CONTROL, 32'h0, RESP_OKAY);
        wait_rst(1'b1, 14000, 16700);
        wait_rst(1'b0, 6, 200);
        rd_reg(OFF_STATUS, RESP_OKAY);
        chk("wdt_cause_flag", {rd[4:2], rd[0]}, {CAUSE_WDT, 1'b1});
        // long pin hold keeps reset up, cycle follows the fall
        u_reset_source_model.set_pin(1'b1);
        repeat (100) @(posedge clk_in);
        chk("held_reset", sys_reset_out, 1'b1);
        chk("lcd_lit", lcd_all_lit_out, 1'b1);
        u_reset_source_model.set_pin(1'b0);
        wait_rst(1'b0, 6, 60);
        rd_reg(OFF_STATUS, RESP_OKAY);
        chk("pin_cause_flag", {rd[4:2], rd[0]}, {CAUSE_PIN, 1'b0});
        // one selected key released: no reset
        u_reset_source_model.set_keys(4'b1110, 1'b1);
        repeat (20) @(posedge clk_in);
        chk("partial_keys", sys_reset_out, 1'b0);
        // both selected keys low, unselected ones high: reset
        u_reset_source_model.set_keys(4'b1100, 1'b1);
        wait_rst(1'b1, 1, 12);
        u_reset_source_model.set_keys(4'hf, 1'b0);
        wait_rst(1'b0, 6, 200);
        rd_reg(OFF_STATUS, RESP_OKAY);
        chk("key_cause", rd[4:2], CAUSE_KEY);
        // pin 0 in output mode drops out: pin 1 low alone is enough
        key_input_mode_in <= 4'h2;
        u_reset_source_model.set_keys(4'b1101, 1'b1);
        wait_rst(1'b1, 1, 12);
        u_reset_source_model.set_keys(4'hf, 1'b0);
        key_input_mode_in <= 4'hf;
        wait_rst(1'b0, 6, 200);
        // a kick with its byte strobe off is ignored
        wstrb_in <= 4'h0;
        wr(OFF_CONTROL, 32'h1, RESP_OKAY);
        wstrb_in <= 4'hf;
        chk("masked_kick", watchdog_enabled_flag_out, 1'b0);
        // power-on request drops an enabled watchdog
        wr(OFF_CONTROL, 32'h1, RESP_OKAY);
        u_reset_source_model.set_por(1'b1);
        repeat (20) @(posedge clk_in);
        chk("por_reset", sys_reset_out, 1'b1);
        u_reset_source_model.set_por(1'b0);
        wait_rst(1'b0, 6, 200);
        rd_reg(OFF_STATUS, RESP_OKAY);
        chk("por_cause_flag", {rd[4:2], rd[0]}, {CAUSE_POR, 1'b0});
        stop_test;
    end
endmodule
